// ===== include/tcc_map.vh
// constants for the timer channel capture core
// Behaviour
// R1 - 16-bit up-counter, readable any time
// R2 - wrap ffff to zero sets overflow flag
// R3 - clock: aclk/2,8,32,128,1024 or ext 0-2
// R4 - ext clocks from pins or chained lines
// R5 - clock invert flips counting edge
// R6 - gate passes clock while gate high
// R7 - ext signals slower than system clock
// R8 - enable/disable commands, b-capture, c-match disable
// R9 - disabled ignores start/stop; running flag
// R10 - trigger starts; b-capture/c-match stops clock
// R11 - mode bit: capture inputs, generation outputs
// R12 - soft trigger command triggers channel
// R13 - block sync triggers all channels
// R14 - c-match triggers when enabled
// R15 - generation external event trigger when enabled
// R16 - trigger zeroes counter at next edge
// R17 - edge settings load capture a and b
// R18 - a/b load sequencing
// R19 - reload before read sets overrun
// R20 - capture ext trigger source and edge
// R21 - status flags since last read
// R22 - channel drives interrupt line
// R23 - read clears flags; irq on masked flags
`ifndef TCC_MAP_VH
`define TCC_MAP_VH
`define TCC_CNT_MAX 16'hFFFF
`define TCC_CNT_ZERO 16'h0000
// clock select codes
`define TCC_CLK_DIV2 3'h0
`define TCC_CLK_DIV8 3'h1
`define TCC_CLK_DIV32 3'h2
`define TCC_CLK_DIV128 3'h3
`define TCC_CLK_DIV1024 3'h4
`define TCC_CLK_EXT0 3'h5
`define TCC_CLK_EXT1 3'h6
`define TCC_CLK_EXT2 3'h7
// edge codes
`define TCC_EDGE_NONE 2'h0
`define TCC_EDGE_RISE 2'h1
`define TCC_EDGE_FALL 2'h2
`define TCC_EDGE_BOTH 2'h3
// status bit positions
`define TCC_ST_OVF 0
`define TCC_ST_OVR 1
`define TCC_ST_CMC 2
`define TCC_ST_LDA 3
`define TCC_ST_LDB 4
`define TCC_ST_ETR 5
`define TCC_ST_W 6
`define TCC_PRESC_W 10
`endif

// ===== design/tcc_edge_det.v
// edge detector on a synchronous level
`timescale 1ns/1ps
module tcc_edge_det (
	input wire ref_clk,
	input wire rst,
	input wire sig,
	output wire rise,
	output wire fall
);
	reg prev; // last sampled level
	// remember previous level
	always @(posedge ref_clk) begin
		// follow the pin during reset, so a line idling high gives no false edge
		if (rst) begin
			prev <= sig;
		end else begin
			prev <= sig;
		end
	end
	assign rise = sig & ~prev;
	assign fall = ~sig & prev;
endmodule

// ===== design/tcc_prescaler.v
// free-running divider giving one-cycle ticks
`timescale 1ns/1ps
`include "tcc_map.vh"
module tcc_prescaler #(
	parameter W = `TCC_PRESC_W
) (
	input wire ref_clk,
	input wire rst,
	output wire [4:0] tick
);
	reg [W-1:0] cnt; // free divider
	// count every cycle; a tick marks the rising edge of each divided clock
	always @(posedge ref_clk) begin
		if (rst) begin
			cnt <= {W{1'b0}};
		end else begin
			cnt <= cnt + {{(W-1){1'b0}}, 1'b1};
		end
	end
	// ticks at /2,/8,/32,/128,/1024 [R3]
	assign tick[0] = cnt[0];
	assign tick[1] = &cnt[2:0];
	assign tick[2] = &cnt[4:0];
	assign tick[3] = &cnt[6:0];
	assign tick[4] = &cnt[9:0];
endmodule

// ===== design/tcc_channel.v
// one timer channel: counter core, clock control, triggers, capture
`timescale 1ns/1ps
`include "tcc_map.vh"
module tcc_channel #(
	parameter CW = 16
) (
	input wire ref_clk,
	input wire rst,
	input wire block_clk_pin_0,
	input wire block_clk_pin_1,
	input wire block_clk_pin_2,
	input wire chain_line_a_0,
	input wire chain_line_a_1,
	input wire chain_line_a_2,
	input wire [5:0] block_config_reg,
	input wire io_line_a_in,
	input wire io_line_b_in,
	output wire io_line_a_oe,
	output wire io_line_b_oe,
	input wire wave_mode,
	input wire [2:0] clock_select,
	input wire clock_invert,
	input wire [1:0] gate_select,
	input wire disable_on_b_capture,
	input wire stop_on_b_capture,
	input wire disable_on_c_match,
	input wire stop_on_c_match,
	input wire trigger_on_c_match,
	input wire [1:0] capture_a_edge,
	input wire [1:0] capture_b_edge,
	input wire ext_trigger_source,
	input wire [1:0] ext_trigger_edge,
	input wire [1:0] ext_event_select,
	input wire [1:0] ext_event_edge,
	input wire ext_event_trigger_enable,
	input wire [CW-1:0] compare_reg_c,
	input wire clock_enable_cmd,
	input wire clock_disable_cmd,
	input wire soft_trigger_cmd,
	input wire block_sync_cmd,
	input wire read_status,
	input wire read_a,
	input wire read_b,
	input wire [`TCC_ST_W-1:0] irq_mask,
	output reg [CW-1:0] counter_value_reg,
	output reg [CW-1:0] capture_reg_a,
	output reg [CW-1:0] capture_reg_b,
	output reg [`TCC_ST_W-1:0] channel_status_reg,
	output reg clock_running_flag,
	output reg irq
);
	// ************************************************************
	// helper functions
	// ************************************************************
	// edge match against a two-bit edge code
	function edge_hit;
		input [1:0] code;
		input r;
		input f;
		begin
			edge_hit = ((code == `TCC_EDGE_RISE) & r) | ((code == `TCC_EDGE_FALL) & f) |
				((code == `TCC_EDGE_BOTH) & (r | f));
		end
	endfunction
	// pick one of three external clocks, code 0 means none
	function pick3;
		input [1:0] sel;
		input [2:0] v;
		begin
			case (sel)
				2'h1: pick3 = v[0];
				2'h2: pick3 = v[1];
				2'h3: pick3 = v[2];
				default: pick3 = 1'b0;
			endcase
		end
	endfunction
	// ************************************************************
	// external clock routing
	// ************************************************************
	reg [2:0] ext_clk; // ext_clk_in_0..2 after block routing
	// each input takes a pin or another channel's line a [R4]
	always @* begin
		case (block_config_reg[1:0])
			2'h0: ext_clk[0] = block_clk_pin_0;
			2'h2: ext_clk[0] = chain_line_a_1;
			2'h3: ext_clk[0] = chain_line_a_2;
			default: ext_clk[0] = 1'b0;
		endcase
		case (block_config_reg[3:2])
			2'h0: ext_clk[1] = block_clk_pin_1;
			2'h2: ext_clk[1] = chain_line_a_0;
			2'h3: ext_clk[1] = chain_line_a_2;
			default: ext_clk[1] = 1'b0;
		endcase
		case (block_config_reg[5:4])
			2'h0: ext_clk[2] = block_clk_pin_2;
			2'h2: ext_clk[2] = chain_line_a_0;
			2'h3: ext_clk[2] = chain_line_a_1;
			default: ext_clk[2] = 1'b0;
		endcase
	end
	// ************************************************************
	// clock edge selection
	// ************************************************************
	wire [4:0] div_tick; // internal divided clock ticks
	tcc_prescaler #(.W(`TCC_PRESC_W)) u_presc (
		.ref_clk(ref_clk),
		.rst(rst),
		.tick(div_tick)
	);
	reg ext_sel_lvl; // selected external clock, before inversion
	// external clocks are sampled; caller keeps them slow enough [R7]
	always @* begin
		case (clock_select)
			`TCC_CLK_EXT0: ext_sel_lvl = ext_clk[0];
			`TCC_CLK_EXT1: ext_sel_lvl = ext_clk[1];
			`TCC_CLK_EXT2: ext_sel_lvl = ext_clk[2];
			default: ext_sel_lvl = 1'b0;
		endcase
	end
	wire ext_rise;
	wire ext_fall;
	tcc_edge_det u_ext_clk (
		.ref_clk(ref_clk),
		.rst(rst),
		.sig(ext_sel_lvl),
		.rise(ext_rise),
		.fall(ext_fall)
	);
	reg [4:0] div_tick_d; // delayed ticks stand in for the falling half
	always @(posedge ref_clk) begin
		if (rst) begin
			div_tick_d <= 5'h00;
		end else begin
			div_tick_d <= div_tick;
		end
	end
	reg raw_edge; // active edge of the chosen clock
	// source choice and inversion [R3] [R5]
	always @* begin
		case (clock_select)
			`TCC_CLK_DIV2: raw_edge = clock_invert ? div_tick_d[0] : div_tick[0];
			`TCC_CLK_DIV8: raw_edge = clock_invert ? div_tick_d[1] : div_tick[1];
			`TCC_CLK_DIV32: raw_edge = clock_invert ? div_tick_d[2] : div_tick[2];
			`TCC_CLK_DIV128: raw_edge = clock_invert ? div_tick_d[3] : div_tick[3];
			`TCC_CLK_DIV1024: raw_edge = clock_invert ? div_tick_d[4] : div_tick[4];
			default: raw_edge = clock_invert ? ext_fall : ext_rise;
		endcase
	end
	// gate lets the edge through only while its signal is high [R6]
	wire gate_ok = (gate_select == 2'h0) | pick3(gate_select, ext_clk);
	// ************************************************************
	// io lines and event detection
	// ************************************************************
	// capture mode: both inputs; generation: a out, b out unless event select 0 takes the event from line b [R11]
	assign io_line_a_oe = wave_mode;
	assign io_line_b_oe = wave_mode & (ext_event_select != 2'h0);
	wire a_rise;
	wire a_fall;
	wire b_rise;
	wire b_fall;
	tcc_edge_det u_line_a (
		.ref_clk(ref_clk),
		.rst(rst),
		.sig(io_line_a_in),
		.rise(a_rise),
		.fall(a_fall)
	);
	tcc_edge_det u_line_b (
		.ref_clk(ref_clk),
		.rst(rst),
		.sig(io_line_b_in),
		.rise(b_rise),
		.fall(b_fall)
	);
	wire [2:0] ext_lvl_rise; // edges of the raw external clocks for events
	wire [2:0] ext_lvl_fall;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_evt
			tcc_edge_det u_evt (
				.ref_clk(ref_clk),
				.rst(rst),
				.sig(ext_clk[gi]),
				.rise(ext_lvl_rise[gi]),
				.fall(ext_lvl_fall[gi])
			);
		end
	endgenerate
	// capture external trigger: line a or b, edge code zero disables [R20]
	wire cap_ext_trig = ~wave_mode & (ext_trigger_source ?
		edge_hit(ext_trigger_edge, a_rise, a_fall) :
		edge_hit(ext_trigger_edge, b_rise, b_fall));
	reg evt_r; // selected generation event edges
	reg evt_f;
	// event on line b (select 0) or an external clock input [R15]
	always @* begin
		case (ext_event_select)
			2'h0: begin
				evt_r = b_rise;
				evt_f = b_fall;
			end
			2'h1: begin
				evt_r = ext_lvl_rise[0];
				evt_f = ext_lvl_fall[0];
			end
			2'h2: begin
				evt_r = ext_lvl_rise[1];
				evt_f = ext_lvl_fall[1];
			end
			default: begin
				evt_r = ext_lvl_rise[2];
				evt_f = ext_lvl_fall[2];
			end
		endcase
	end
	wire gen_event = wave_mode & edge_hit(ext_event_edge, evt_r, evt_f);
	wire gen_ext_trig = gen_event & ext_event_trigger_enable; // [R15]
	wire ext_trig = cap_ext_trig | gen_ext_trig;
	// ************************************************************
	// capture and compare events
	// ************************************************************
	reg a_armed; // a may load: none since trigger, or b since last a
	reg b_armed; // b may load: a has loaded since trigger or last b
	wire c_match = (counter_value_reg == compare_reg_c);
	reg c_match_d; // match seen on previous cycle, for one event per hit
	wire c_event = c_match & ~c_match_d;
	wire load_a = ~wave_mode & edge_hit(capture_a_edge, a_rise, a_fall) & a_armed; // [R17] [R18]
	wire load_b = ~wave_mode & edge_hit(capture_b_edge, a_rise, a_fall) & b_armed; // [R17] [R18]
	// all trigger kinds merged [R12] [R13] [R14]
	wire trig = soft_trigger_cmd | block_sync_cmd | (trigger_on_c_match & c_event) | ext_trig;
	wire stop_evt = (~wave_mode & load_b & stop_on_b_capture) |
		(wave_mode & c_event & stop_on_c_match); // [R10]
	wire dis_evt = (~wave_mode & load_b & disable_on_b_capture) |
		(wave_mode & c_event & disable_on_c_match); // [R8]
	// ************************************************************
	// clock control
	// ************************************************************
	reg clk_started; // start/stop state
	reg trig_pend; // trigger waits for the next active edge
	// disable by command or event wins over enable; enable only by command [R8] [R9]
	always @(posedge ref_clk) begin
		if (rst) begin
			clock_running_flag <= 1'b0;
			clk_started <= 1'b0;
		end else begin
			if (clock_disable_cmd | dis_evt) begin
				clock_running_flag <= 1'b0;
			end else if (clock_enable_cmd) begin
				clock_running_flag <= 1'b1;
			end
			// start and stop only while enabled [R9] [R10]
			if (clock_running_flag) begin
				if (trig) begin
					clk_started <= 1'b1;
				end else if (stop_evt) begin
					clk_started <= 1'b0;
				end
			end
		end
	end
	wire cnt_edge = raw_edge & gate_ok & clock_running_flag & clk_started;
	// ************************************************************
	// counter
	// ************************************************************
	// count up; pending trigger zeroes it on the next active edge [R1] [R16]
	always @(posedge ref_clk) begin
		if (rst) begin
			counter_value_reg <= {CW{1'b0}};
			trig_pend <= 1'b0;
			c_match_d <= 1'b1; // counter and c both reset to zero: not a match event
		end else begin
			c_match_d <= c_match;
			if (cnt_edge) begin
				trig_pend <= trig;
				if (trig_pend) begin
					counter_value_reg <= {CW{1'b0}};
				end else begin
					counter_value_reg <= counter_value_reg + {{(CW-1){1'b0}}, 1'b1};
				end
			end else if (trig) begin
				trig_pend <= 1'b1;
			end
		end
	end
	// wrap from all ones while counting, not on a trigger reset [R2]
	wire ovf_evt = cnt_edge & ~trig_pend & (&counter_value_reg);
	// ************************************************************
	// capture registers
	// ************************************************************
	reg a_unread; // a holds a value not yet read
	reg b_unread; // b holds a value not yet read
	// load with sequencing; trigger rearms a and disarms b [R18] [R19]
	always @(posedge ref_clk) begin
		if (rst) begin
			capture_reg_a <= {CW{1'b0}};
			capture_reg_b <= {CW{1'b0}};
			a_armed <= 1'b1;
			b_armed <= 1'b0;
			a_unread <= 1'b0;
			b_unread <= 1'b0;
		end else begin
			if (load_a) begin
				capture_reg_a <= counter_value_reg;
			end
			if (load_b) begin
				capture_reg_b <= counter_value_reg;
			end
			if (trig) begin
				a_armed <= 1'b1;
				b_armed <= 1'b0;
			end else if (load_a) begin
				a_armed <= 1'b0;
				b_armed <= 1'b1;
			end else if (load_b) begin
				a_armed <= 1'b1;
				b_armed <= 1'b0;
			end
			// a load in the read cycle still counts as unread
			a_unread <= load_a | (a_unread & ~read_a);
			b_unread <= load_b | (b_unread & ~read_b);
		end
	end
	wire ovr_evt = (load_a & a_unread & ~read_a) | (load_b & b_unread & ~read_b); // [R19]
	// ************************************************************
	// status and interrupt
	// ************************************************************
	reg [`TCC_ST_W-1:0] evt_vec; // this cycle's events
	always @* begin
		evt_vec = {`TCC_ST_W{1'b0}};
		evt_vec[`TCC_ST_OVF] = ovf_evt;
		evt_vec[`TCC_ST_OVR] = ovr_evt;
		evt_vec[`TCC_ST_CMC] = c_event;
		evt_vec[`TCC_ST_LDA] = load_a;
		evt_vec[`TCC_ST_LDB] = load_b;
		evt_vec[`TCC_ST_ETR] = ext_trig;
	end
	// sticky flags; a read clears, but a same-cycle event wins [R21] [R23]
	always @(posedge ref_clk) begin
		if (rst) begin
			channel_status_reg <= {`TCC_ST_W{1'b0}};
			irq <= 1'b0;
		end else begin
			channel_status_reg <= evt_vec | (channel_status_reg & {`TCC_ST_W{~read_status}});
			// irq follows masked flags [R22] [R23]
			irq <= |((evt_vec | (channel_status_reg & {`TCC_ST_W{~read_status}})) & irq_mask);
		end
	end
endmodule

// ===== testbench/tcc_monitor.sv
// assertion checker watching the timer channel ports
`timescale 1ns/1ps
`include "tcc_map.vh"
module tcc_monitor #(
	parameter CW = 16
) (
	input wire ref_clk,
	input wire rst,
	input wire wave_mode,
	input wire [2:0] clock_select,
	input wire [1:0] gate_select,
	input wire [1:0] ext_event_select,
	input wire clock_enable_cmd,
	input wire clock_disable_cmd,
	input wire soft_trigger_cmd,
	input wire block_sync_cmd,
	input wire read_status,
	input wire [`TCC_ST_W-1:0] irq_mask,
	input wire [CW-1:0] counter_value_reg,
	input wire [CW-1:0] capture_reg_a,
	input wire [`TCC_ST_W-1:0] channel_status_reg,
	input wire clock_running_flag,
	input wire irq,
	input wire io_line_a_oe,
	input wire io_line_b_oe
);
// ****************
// clock and disable shared by all properties
// ****************
default clocking cb @(posedge ref_clk); endclocking
default disable iff (rst);
// the first active /2 edge after a trigger lands within a few cycles
sequence s_zero;
	##[1:5] counter_value_reg == '0;
endsequence
property p_en_run;
	clock_enable_cmd && !clock_disable_cmd |=> clock_running_flag;
endproperty
a_en_run: assert property (p_en_run) else $error("enable did not run");
property p_dis;
	clock_disable_cmd |=> !clock_running_flag;
endproperty
a_dis: assert property (p_dis) else $error("disable ignored");
property p_idle;
	!clock_running_flag && !clock_enable_cmd |=> !clock_running_flag;
endproperty
a_idle: assert property (p_idle) else $error("clock woke alone");
property p_frozen;
	!clock_running_flag [*4] |-> $stable(counter_value_reg);
endproperty
a_frozen: assert property (p_frozen) else $error("count while disabled");
property p_step;
	counter_value_reg != $past(counter_value_reg) |->
		counter_value_reg == $past(counter_value_reg) + 1'b1 || counter_value_reg == '0;
endproperty
a_step: assert property (p_step) else $error("count jumped");
property p_trig_zero;
	(soft_trigger_cmd || block_sync_cmd) && clock_running_flag && !clock_disable_cmd
		&& clock_select == `TCC_CLK_DIV2 && gate_select == 2'h0 |-> s_zero;
endproperty
a_trig_zero: assert property (p_trig_zero) else $error("trigger no zero");
property p_irq_on;
	|(channel_status_reg & irq_mask) && !read_status |=> irq;
endproperty
a_irq_on: assert property (p_irq_on) else $error("irq missing");
property p_a_flag;
	$changed(capture_reg_a) |-> channel_status_reg[`TCC_ST_LDA];
endproperty
a_a_flag: assert property (p_a_flag) else $error("load a unflagged");
property p_oe;
	io_line_a_oe == wave_mode && io_line_b_oe == (wave_mode && ext_event_select != 2'h0);
endproperty
a_oe: assert property (p_oe) else $error("line direction wrong");
endmodule
bind tcc_channel tcc_monitor #(.CW(CW)) u_mon (.*);

// ===== testbench/tcc_far_end.sv
// far end model: external clock pins and measured lines
`timescale 1ns/1ps
module tcc_far_end (
	input wire ref_clk,
	input wire ext_run,
	input wire gate_lvl,
	input wire line_a_lvl,
	output logic block_clk_pin_0,
	output logic block_clk_pin_1,
	output logic block_clk_pin_2,
	output logic chain_line_a_1,
	output logic io_line_a_in,
	output logic io_line_b_in
);
logic [1:0] ph; // phase within one clock level
// ****************
// slow external clock, still outside runs
// ****************
// one driver per pin; levels settle on the first edge, well inside reset
always @(posedge ref_clk) begin
	if (!ext_run) begin
		ph <= 2'h0;
		block_clk_pin_0 <= 1'b0; // parked low between runs
	end else if (ph == 2'h2) begin
		ph <= 2'h0;
		block_clk_pin_0 <= ~block_clk_pin_0; // 3-cycle levels, period 6
	end else begin
		ph <= ph + 2'h1;
	end
	block_clk_pin_1 <= gate_lvl; // gate level from the bench
	io_line_a_in <= line_a_lvl; // held many cycles, above one period
	io_line_b_in <= ~line_a_lvl; // line b moves opposite to line a
end
assign block_clk_pin_2 = block_clk_pin_0;
assign chain_line_a_1 = block_clk_pin_0; // a chained neighbour's line a
endmodule

// ===== testbench/tb.sv
// self-checking testbench for the timer channel core
`timescale 1ns/1ps
module tb;
// ****************
// signals
// ****************
logic ref_clk, rst; // 200 MHz clock, sync reset
logic wave_mode, clock_invert, disable_on_b_capture, stop_on_b_capture;
logic disable_on_c_match, stop_on_c_match, trigger_on_c_match, ext_trigger_source;
logic ext_event_trigger_enable, ext_run, gate_lvl, line_a_lvl; // last three steer far end
logic [2:0] clock_select;
logic [1:0] gate_select, capture_a_edge, capture_b_edge, ext_trigger_edge;
logic [1:0] ext_event_select, ext_event_edge;
logic [5:0] block_config_reg, irq_mask;
logic [15:0] compare_reg_c, v; // v holds a sampled count
logic [6:0] cmd; // one-cycle command strobes
int seed, num_errors, num_checks, i;
int dv[5] = '{2, 8, 32, 128, 1024}; // internal division ratios
wire clock_enable_cmd = cmd[0];
wire clock_disable_cmd = cmd[1];
wire soft_trigger_cmd = cmd[2];
wire block_sync_cmd = cmd[3];
wire read_status = cmd[4];
wire read_a = cmd[5];
wire read_b = cmd[6];
wire chain_line_a_0 = 1'b0; // unused chain sources
wire chain_line_a_2 = 1'b0;
wire block_clk_pin_0, block_clk_pin_1, block_clk_pin_2, chain_line_a_1;
wire io_line_a_in, io_line_b_in, io_line_a_oe, io_line_b_oe, clock_running_flag, irq;
wire [15:0] counter_value_reg, capture_reg_a, capture_reg_b;
wire [5:0] channel_status_reg;
tcc_channel #(.CW(16)) dut (.*);
tcc_far_end far (.*);
// ****************
// helpers
// ****************
function automatic int f_exp(input int span, input int per);
	return (per == 0) ? 0 : span / per; // whole source edges in a span
endfunction
task automatic tick(input int n);
	repeat (n) @(negedge ref_clk);
endtask
task automatic issue(input logic [6:0] c);
	cmd = c;
	tick(1);
	cmd = 7'h00;
	tick(1); // idle cycle, so a following call never re-drives cmd at once
endtask
task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
	num_checks++;
	if (got !== exp) begin
		num_errors++;
		$display("Error at %0t: got %h expected %h", $time, got, exp);
	end
endtask
task automatic chk_f(input logic got, input logic exp);
	chk_v({15'h0000, got}, {15'h0000, exp});
endtask
// settle first, since a fresh source may shift phase once
task automatic meas(input int span, input int per);
	tick(2 * per + 8);
	v = counter_value_reg;
	tick(span);
	chk_v(counter_value_reg - v, 16'(f_exp(span, per)));
endtask
task automatic pa();
	line_a_lvl = 1'b1;
	tick(6);
	line_a_lvl = 1'b0;
	tick(6);
endtask
task automatic end_sim();
	$display("checks %0d errors %0d", num_checks, num_errors);
	if (num_errors == 0 && num_checks > 0) $display("verification passed");
	else $display("verification failed");
	$finish;
endtask
// ****************
// clock and watchdog
// ****************
initial begin
	ref_clk = 1'b0;
	forever #2.5 ref_clk = ~ref_clk;
end
initial begin
	#300000;
	num_errors++; // run hung
	end_sim();
end
// ****************
// main sequence
// ****************
initial begin
	{wave_mode, clock_invert, disable_on_b_capture, stop_on_b_capture} = 4'h0;
	{disable_on_c_match, stop_on_c_match, trigger_on_c_match, ext_trigger_source} = 4'h0;
	{ext_event_trigger_enable, ext_run, gate_lvl, line_a_lvl} = 4'h0;
	{clock_select, gate_select, capture_a_edge, capture_b_edge} = 9'h000;
	{ext_trigger_edge, ext_event_select, ext_event_edge} = 6'h00;
	{block_config_reg, irq_mask, cmd} = 19'h0_0000;
	compare_reg_c = 16'h0000;
	seed = 33;
	rst = 1'b1;
	tick(16);
	rst = 1'b0;
	tick(1);
	chk_v(counter_value_reg | capture_reg_a | channel_status_reg, 16'h0000);
	issue(7'h01);
	issue(7'h04);
	chk_f(clock_running_flag, 1'b1);
	for (i = 0; i < 5; i++) begin
		clock_select = i[2:0];
		clock_invert = 1'($random(seed)); // either edge gives the same rate
		meas(3 * dv[i], dv[i]);
	end
	{clock_select, ext_run, clock_invert} = 5'h16; // ext0 from its pin, running
	meas(60, 6);
	block_config_reg = 6'h01; // ext0 tied low: routing must cut the pin
	meas(60, 0);
	block_config_reg = 6'h02; // ext0 from the chained line
	meas(60, 6);
	{gate_select, gate_lvl} = 3'h4;
	meas(60, 0);
	gate_lvl = 1'b1;
	meas(60, 6);
	{gate_select, ext_run, clock_select, block_config_reg} = 12'h000;
	issue(7'h08);
	tick(6);
	chk_f(counter_value_reg < 16'h0004, 1'b1);
	issue(7'h02);
	chk_f(clock_running_flag, 1'b0);
	v = counter_value_reg;
	issue(7'h04);
	tick(20);
	chk_v(counter_value_reg, v);
	issue(7'h01);
	compare_reg_c = 16'h0008 + (16'($random(seed)) & 16'h001f);
	trigger_on_c_match = 1'b1;
	issue(7'h04);
	tick(2 * compare_reg_c + 20);
	chk_f(channel_status_reg[2], 1'b1);
	chk_f(counter_value_reg <= compare_reg_c, 1'b1);
	irq_mask = 6'h04;
	tick(2);
	chk_f(irq, 1'b1);
	irq_mask = 6'h00;
	tick(2);
	chk_f(irq, 1'b0);
	{trigger_on_c_match, capture_a_edge, capture_b_edge} = 5'h06;
	issue(7'h04);
	tick(10);
	issue(7'h10);
	pa();
	chk_v(capture_reg_b - capture_reg_a, 16'h0003);
	chk_v({10'h000, channel_status_reg & 6'h1a}, 16'h0018);
	pa();
	chk_f(channel_status_reg[1], 1'b1);
	issue(7'h70);
	tick(1);
	chk_v({10'h000, channel_status_reg & 6'h3b}, 16'h0000);
	capture_b_edge = 2'h0;
	issue(7'h04);
	tick(6);
	pa();
	v = capture_reg_a;
	pa();
	chk_v(capture_reg_a, v);
	{capture_b_edge, stop_on_b_capture} = 3'h5;
	issue(7'h04);
	tick(6);
	pa();
	v = counter_value_reg;
	tick(10);
	chk_v(counter_value_reg, v);
	chk_f(clock_running_flag, 1'b1);
	{stop_on_b_capture, disable_on_b_capture} = 2'h1;
	issue(7'h04);
	tick(6);
	pa();
	chk_f(clock_running_flag, 1'b0);
	{disable_on_b_capture, capture_a_edge, capture_b_edge} = 5'h00;
	issue(7'h01);
	issue(7'h04);
	for (i = 0; i < 4; i++) begin
		ext_trigger_edge = i[1:0];
		ext_trigger_source = 1'($random(seed));
		issue(7'h10);
		pa();
		chk_f(channel_status_reg[5], i != 0);
	end
	{ext_trigger_edge, wave_mode} = 3'h1;
	for (i = 0; i < 4; i++) begin
		ext_event_select = i[1:0];
		tick(1);
		chk_f(io_line_b_oe, i != 0);
	end
	chk_f(io_line_a_oe, 1'b1);
	{ext_event_select, stop_on_c_match} = 3'h1;
	issue(7'h04);
	tick(2 * compare_reg_c + 20);
	v = counter_value_reg;
	tick(8);
	chk_v(counter_value_reg, v);
	{stop_on_c_match, disable_on_c_match} = 2'h1;
	issue(7'h04);
	tick(2 * compare_reg_c + 20);
	chk_f(clock_running_flag, 1'b0);
	{disable_on_c_match, ext_event_edge} = 3'h1;
	issue(7'h01);
	issue(7'h04);
	for (i = 0; i < 2; i++) begin
		ext_event_trigger_enable = i[0];
		tick(40);
		pa();
		chk_f(counter_value_reg < 16'h0008, i[0]);
	end
	end_sim();
end
endmodule
